// File: inc/cdt_regs.svh
`ifndef CDT_REGS_SVH
`define CDT_REGS_SVH

// ********************************************************
// Register byte offsets
// ********************************************************
`define CDT_OFF_EVEN_CTRL   8'h00
`define CDT_OFF_ODD_CTRL    8'h04
`define CDT_OFF_CNT_LOW     8'h08
`define CDT_OFF_CNT_HIGH    8'h0C
`define CDT_OFF_PER_LOW     8'h10
`define CDT_OFF_PER_HIGH    8'h14
`define CDT_OFF_STATUS      8'h18
`define CDT_OFF_MASK        8'h1C

// ********************************************************
// Control field positions
// ********************************************************
`define CDT_BIT_RUN         15
`define CDT_BIT_IDLE_HALT   13
`define CDT_BIT_GATE        6
`define CDT_BIT_PRE_HI      5
`define CDT_BIT_PRE_LO      4
`define CDT_BIT_PAIR        3
`define CDT_BIT_CLK_SRC     1

// Implemented bits of each control word
`define CDT_EVEN_IMPL       16'hA07A
`define CDT_ODD_IMPL        16'hA072

// ********************************************************
// Reset values
// ********************************************************
`define CDT_RST_CTRL        7'h00
`define CDT_RST_COUNT       16'h0000
`define CDT_RST_PERIOD      16'hFFFF
`define CDT_RST_IRQ         2'h0

// ********************************************************
// Prescaler terminal counts (ratio minus one)
// ********************************************************
`define CDT_PRE_LIM_1       8'h00
`define CDT_PRE_LIM_8       8'h07
`define CDT_PRE_LIM_64      8'h3F
`define CDT_PRE_LIM_256     8'hFF

`endif

// File: inc/cdt_pkg.sv
`default_nettype none

// ********************************************************
// Shared types of the timer pair
// ********************************************************
package cdt_pkg;

  // Implemented control bits, same layout for both timers
  typedef struct packed {
    logic       run_enable;
    logic       idle_halt;
    logic       gate_accumulate;
    logic [1:0] prescale_select;
    logic       pair_join;
    logic       clock_source_select;
  } cdt_ctrl_t;

  // Bus slave states
  typedef enum logic [2:0] {
    CDT_BUS_IDLE = 3'b001,
    CDT_BUS_WR   = 3'b010,
    CDT_BUS_RD   = 3'b100
  } cdt_bus_t;

  // Edge and level view of the synchronised pins
  typedef struct packed {
    logic [1:0] level;
    logic [1:0] rise;
    logic [1:0] fall;
  } cdt_pins_t;

endpackage

`default_nettype wire

// File: rtl/cdt_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// Pin synchroniser with edge detection
// ********************************************************
module cdt_pin_sync #(
  parameter int N      = 2,
  parameter int STAGES = 2
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic [N-1:0]           pins,
  output var cdt_pkg::cdt_pins_t      sync
);

  generate
    if (N != 2) begin : g_bad_n
      $error("cdt_pin_sync serves exactly two pins");
    end
    if (STAGES < 2) begin : g_bad_stages
      $error("cdt_pin_sync needs at least two stages");
    end
  endgenerate

  // One chain per pin; the first stage feeds only the next stage
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      logic [STAGES-1:0] chain_q;
      logic [STAGES-1:0] chain_d;
      logic              prev_q;
      logic              prev_d;

      always_comb
      begin
        chain_d = {chain_q[STAGES-2:0], pins[i]};
        prev_d  = chain_q[STAGES-1];
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          chain_q <= '0;
          prev_q  <= 1'b0;
        end
        else
        begin
          chain_q <= chain_d;
          prev_q  <= prev_d;
        end
      end

      assign sync.level[i] = chain_q[STAGES-1];
      assign sync.rise[i]  = chain_q[STAGES-1] & ~prev_q;
      assign sync.fall[i]  = ~chain_q[STAGES-1] & prev_q;
    end
  endgenerate

endmodule

`default_nettype wire

// File: rtl/cdt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdt_regs.svh"

// ********************************************************
// Input clock prescaler, 1:1 / 1:8 / 1:64 / 1:256
// ********************************************************
module cdt_prescaler #(
  parameter int W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         tick_in,
  input  wire logic [1:0]   select,
  input  wire logic         clear,
  output logic              tick_out,
  output logic [W-1:0]      count
);

  generate
    if (W < 8) begin : g_bad_w
      $error("cdt_prescaler needs at least eight bits for 1:256");
    end
  endgenerate

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] limit;

  // Terminal count per ratio; clear beats a tick so a rewrite restarts
  always_comb
  begin
    case (select)
      2'b00:   limit = W'(`CDT_PRE_LIM_1);
      2'b01:   limit = W'(`CDT_PRE_LIM_8);
      2'b10:   limit = W'(`CDT_PRE_LIM_64);
      2'b11:   limit = W'(`CDT_PRE_LIM_256);
      default: limit = W'(`CDT_PRE_LIM_1);
    endcase
    tick_out = 1'b0;
    cnt_d    = cnt_q;
    if (clear)
      cnt_d = '0;
    else if (tick_in)
    begin
      if (cnt_q >= limit)
      begin
        cnt_d    = '0;
        tick_out = 1'b1;
      end
      else
        cnt_d = W'(cnt_q + 1'b1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign count = cnt_q;

endmodule

`default_nettype wire

// File: rtl/cdt_timer_pair.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cdt_regs.svh"

module cdt_timer_pair (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire logic         idle_mode,
  input  wire logic         even_ext_clock_pin,
  input  wire logic         odd_ext_clock_pin,
  output logic              irq,
  output logic              adc_trigger
);

  // ********************************************************
  // Declarations
  // ********************************************************
  cdt_pkg::cdt_bus_t  state_q, state_d;
  logic [7:0]         addr_q, addr_d;
  logic [31:0]        rdata_q, rdata_d;
  logic               ready_q, ready_d;
  logic               wr_en;
  cdt_pkg::cdt_ctrl_t even_q, even_d, odd_q, odd_d;
  logic [15:0]        cnt_lo_q, cnt_lo_d, cnt_hi_q, cnt_hi_d;
  logic [15:0]        per_lo_q, per_lo_d, per_hi_q, per_hi_d;
  logic [1:0]         status_q, status_d, mask_q, mask_d;
  logic               irq_q, irq_d, adc_q, adc_d, half_q;
  logic               wr_even, wr_odd, wr_cnt_lo, wr_cnt_hi;
  logic               run_e, run_o, gate_e, gate_o, int_tick;
  logic               pre_in_e, pre_in_o, clr_e, clr_o, tick_e, tick_o;
  logic               fall_e, fall_o, evt_e, evt_o, match_o;
  logic [7:0]         pre_cnt_e, pre_cnt_o;
  logic [31:0]        cnt32;
  cdt_pkg::cdt_pins_t pins;

  // ********************************************************
  // Pins and prescalers
  // ********************************************************
  cdt_pin_sync #(.N(2), .STAGES(2)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pins    ({odd_ext_clock_pin, even_ext_clock_pin}),
    .sync    (pins)
  );

  cdt_prescaler #(.W(8)) u_pre_even (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tick_in  (pre_in_e),
    .select   (even_q.prescale_select),
    .clear    (clr_e),
    .tick_out (tick_e),
    .count    (pre_cnt_e)
  );

  cdt_prescaler #(.W(8)) u_pre_odd (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tick_in  (pre_in_o),
    .select   (odd_q.prescale_select),
    .clear    (clr_o),
    .tick_out (tick_o),
    .count    (pre_cnt_o)
  );

  // ********************************************************
  // AHB-Lite slave
  // ********************************************************
  // Reads take one wait state so a write just before them is seen
  always_comb
  begin
    state_d = cdt_pkg::CDT_BUS_IDLE;
    addr_d  = addr_q;
    rdata_d = rdata_q;
    ready_d = 1'b1;
    wr_en   = (state_q == cdt_pkg::CDT_BUS_WR);
    case (state_q)
      cdt_pkg::CDT_BUS_IDLE, cdt_pkg::CDT_BUS_WR:
      begin
        if (hsel && hready && htrans[1])
        begin
          addr_d  = {haddr[7:2], 2'b00};
          state_d = hwrite ? cdt_pkg::CDT_BUS_WR : cdt_pkg::CDT_BUS_RD;
          ready_d = hwrite;
        end
      end
      cdt_pkg::CDT_BUS_RD:
      begin
        case (addr_q)
          `CDT_OFF_EVEN_CTRL: rdata_d = {16'h0000, ctrl_word(even_q, 1'b1)};
          `CDT_OFF_ODD_CTRL:  rdata_d = {16'h0000, ctrl_word(odd_q, 1'b0)};
          `CDT_OFF_CNT_LOW:   rdata_d = {16'h0000, cnt_lo_q};
          `CDT_OFF_CNT_HIGH:  rdata_d = {16'h0000, cnt_hi_q};
          `CDT_OFF_PER_LOW:   rdata_d = {16'h0000, per_lo_q};
          `CDT_OFF_PER_HIGH:  rdata_d = {16'h0000, per_hi_q};
          `CDT_OFF_STATUS:    rdata_d = {30'h0, status_q};
          `CDT_OFF_MASK:      rdata_d = {30'h0, mask_q};
          default:            rdata_d = 32'h00000000;
        endcase
      end
      default: state_d = cdt_pkg::CDT_BUS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= cdt_pkg::CDT_BUS_IDLE;
      addr_q  <= 8'h00;
      rdata_q <= 32'h00000000;
      ready_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      addr_q  <= addr_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
    end
  end

  // Only implemented bits exist, so the rest read as zero
  function automatic logic [15:0] ctrl_word(cdt_pkg::cdt_ctrl_t c,
                                            logic even);
    logic [15:0] w;
    w = 16'h0000;
    w[`CDT_BIT_RUN]       = c.run_enable;
    w[`CDT_BIT_IDLE_HALT] = c.idle_halt;
    w[`CDT_BIT_GATE]      = c.gate_accumulate;
    w[`CDT_BIT_PRE_HI]    = c.prescale_select[1];
    w[`CDT_BIT_PRE_LO]    = c.prescale_select[0];
    w[`CDT_BIT_PAIR]      = c.pair_join & even;
    w[`CDT_BIT_CLK_SRC]   = c.clock_source_select;
    return w;
  endfunction

  function automatic cdt_pkg::cdt_ctrl_t ctrl_of(logic [15:0] w,
                                                 logic even);
    cdt_pkg::cdt_ctrl_t c;
    c.run_enable          = w[`CDT_BIT_RUN];
    c.idle_halt           = w[`CDT_BIT_IDLE_HALT];
    c.gate_accumulate     = w[`CDT_BIT_GATE];
    c.prescale_select     = {w[`CDT_BIT_PRE_HI], w[`CDT_BIT_PRE_LO]};
    c.pair_join           = w[`CDT_BIT_PAIR] & even;
    c.clock_source_select = w[`CDT_BIT_CLK_SRC];
    return c;
  endfunction

  // ********************************************************
  // Timer datapath
  // ********************************************************
  // Write strobes and tick sources; the half clock stands for Fosc/2
  assign wr_even   = wr_en && (addr_q == `CDT_OFF_EVEN_CTRL);
  assign wr_odd    = wr_en && (addr_q == `CDT_OFF_ODD_CTRL);
  assign wr_cnt_lo = wr_en && (addr_q == `CDT_OFF_CNT_LOW);
  assign wr_cnt_hi = wr_en && (addr_q == `CDT_OFF_CNT_HIGH);
  assign int_tick  = half_q;
  assign cnt32     = {cnt_hi_q, cnt_lo_q};

  // Gating, idle stop, clock choice and prescaler restart
  always_comb
  begin
    run_e    = even_q.run_enable &&
               !(idle_mode && even_q.idle_halt);
    run_o    = odd_q.run_enable && !even_q.pair_join &&
               !(idle_mode && odd_q.idle_halt);
    gate_e   = even_q.gate_accumulate &&
               !even_q.clock_source_select;
    gate_o   = odd_q.gate_accumulate && !odd_q.clock_source_select;
    pre_in_e = run_e && (!gate_e || pins.level[0]) &&
               (even_q.clock_source_select ? pins.rise[0]
                                           : int_tick);
    pre_in_o = run_o && (!gate_o || pins.level[1]) &&
               (odd_q.clock_source_select ? pins.rise[1]
                                          : int_tick);
    clr_e    = wr_even && even_q.run_enable;
    clr_o    = (wr_odd && odd_q.run_enable) || even_q.pair_join;
    fall_e   = gate_e && run_e && pins.fall[0];
    fall_o   = gate_o && run_o && pins.fall[1];
  end

  // Counting, match and registers that software writes
  always_comb
  begin
    cnt_lo_d = cnt_lo_q;
    cnt_hi_d = cnt_hi_q;
    evt_e    = 1'b0;
    match_o  = 1'b0;
    even_d   = even_q;
    odd_d    = odd_q;
    per_lo_d = per_lo_q;
    per_hi_d = per_hi_q;
    mask_d   = mask_q;
    if (even_q.pair_join)
    begin
      // Odd word is the upper half of count and period
      if (tick_e)
      begin
        if (cnt32 == {per_hi_q, per_lo_q})
        begin
          {cnt_hi_d, cnt_lo_d} = 32'h00000000;
          match_o = 1'b1;
        end
        else
          {cnt_hi_d, cnt_lo_d} = 32'(cnt32 + 32'h00000001);
      end
    end
    else
    begin
      if (tick_e)
      begin
        evt_e    = (cnt_lo_q == per_lo_q);
        cnt_lo_d = evt_e ? 16'h0000
                         : 16'(cnt_lo_q + 16'h0001);
      end
      if (tick_o)
      begin
        match_o  = (cnt_hi_q == per_hi_q);
        cnt_hi_d = match_o ? 16'h0000
                           : 16'(cnt_hi_q + 16'h0001);
      end
      evt_e = evt_e || fall_e;
    end
    evt_o = match_o || fall_o ||
            (even_q.pair_join && fall_e);
    if (wr_even)
      even_d = ctrl_of(hwdata[15:0], 1'b1);
    if (wr_odd)
      odd_d = ctrl_of(hwdata[15:0], 1'b0);
    if (wr_cnt_lo)
      cnt_lo_d = hwdata[15:0];
    if (wr_cnt_hi)
      cnt_hi_d = hwdata[15:0];
    if (wr_en && (addr_q == `CDT_OFF_PER_LOW))
      per_lo_d = hwdata[15:0];
    if (wr_en && (addr_q == `CDT_OFF_PER_HIGH))
      per_hi_d = hwdata[15:0];
    if (wr_en && (addr_q == `CDT_OFF_MASK))
      mask_d = hwdata[1:0];
  end

  // Sticky flags: a new event wins over a write-one clear
  always_comb
  begin
    status_d = status_q;
    if (wr_en && (addr_q == `CDT_OFF_STATUS))
      status_d = status_q & ~hwdata[1:0];
    status_d = status_d | {evt_o, evt_e};
    irq_d    = |(status_d & mask_d);
    adc_d    = match_o;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      even_q   <= `CDT_RST_CTRL;
      odd_q    <= `CDT_RST_CTRL;
      cnt_lo_q <= `CDT_RST_COUNT;
      cnt_hi_q <= `CDT_RST_COUNT;
      per_lo_q <= `CDT_RST_PERIOD;
      per_hi_q <= `CDT_RST_PERIOD;
      status_q <= `CDT_RST_IRQ;
      mask_q   <= `CDT_RST_IRQ;
      irq_q    <= 1'b0;
      adc_q    <= 1'b0;
      half_q   <= 1'b0;
    end
    else
    begin
      even_q   <= even_d;
      odd_q    <= odd_d;
      cnt_lo_q <= cnt_lo_d;
      cnt_hi_q <= cnt_hi_d;
      per_lo_q <= per_lo_d;
      per_hi_q <= per_hi_d;
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
      adc_q    <= adc_d;
      half_q   <= ~half_q;
    end
  end

  assign hrdata      = rdata_q;
  assign hreadyout   = ready_q;
  assign hresp       = 1'b0;
  assign irq         = irq_q;
  assign adc_trigger = adc_q;

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_run_hold;
    !even_q.run_enable && !wr_cnt_lo |=> $stable(cnt_lo_q);
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("low count moved while stopped");

  property p_idle_halt;
    idle_mode && even_q.idle_halt |-> !pre_in_e && !tick_e;
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("even timer ticked in idle with halt set");

  property p_gate_ignored;
    even_q.clock_source_select && pins.rise[0] && run_e |-> pre_in_e;
  endproperty
  a_gate_ignored: assert property (p_gate_ignored)
    else $error("external edge lost under gate bit");

  property p_prescale8;
    tick_e && even_q.prescale_select == 2'b01 |-> pre_cnt_e == 8'h07;
  endproperty
  a_prescale8: assert property (p_prescale8)
    else $error("1:8 tick at wrong prescaler count");

  property p_pair_odd_quiet;
    even_q.pair_join |-> !pre_in_o && !tick_o;
  endproperty
  a_pair_odd_quiet: assert property (p_pair_odd_quiet)
    else $error("odd prescaler active while paired");

  property p_clr_pre;
    wr_even && even_q.run_enable |=> pre_cnt_e == 8'h00;
  endproperty
  a_clr_pre: assert property (p_clr_pre)
    else $error("prescaler not restarted on control write");

  // Odd side restart as well, so the odd prescaler count is watched too
  property p_clr_pre_odd;
    wr_odd && odd_q.run_enable |=> pre_cnt_o == 8'h00;
  endproperty
  a_clr_pre_odd: assert property (p_clr_pre_odd)
    else $error("odd prescaler not restarted on control write");

  property p_adc_only_odd;
    evt_e && !match_o |=> !adc_trigger;
  endproperty
  a_adc_only_odd: assert property (p_adc_only_odd)
    else $error("even event raised converter trigger");

  property p_rsv_zero;
    state_q == cdt_pkg::CDT_BUS_RD && addr_q == `CDT_OFF_EVEN_CTRL
      |=> (hrdata & ~{16'h0000, `CDT_EVEN_IMPL}) == 32'h00000000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved control bits read non-zero");

  property p_match16;
    !even_q.pair_join && tick_e && cnt_lo_q == per_lo_q && !wr_cnt_lo
      |=> cnt_lo_q == 16'h0000 && status_q[0];
  endproperty
  a_match16: assert property (p_match16)
    else $error("16-bit match did not wrap and flag");

  property p_match32;
    even_q.pair_join && tick_e && cnt32 == {per_hi_q, per_lo_q} &&
      !wr_cnt_lo && !wr_cnt_hi
      |=> cnt32 == 32'h00000000 && status_q[1] && adc_trigger;
  endproperty
  a_match32: assert property (p_match32)
    else $error("32-bit match did not wrap and flag odd");

  property p_gate_fall;
    fall_e && !even_q.pair_join |=> status_q[0];
  endproperty
  a_gate_fall: assert property (p_gate_fall)
    else $error("gate falling edge did not set flag");

  c_pair_match: cover property (even_q.pair_join && match_o);
  c_adc: cover property (adc_trigger);
  c_gate_fall: cover property (fall_e);
  c_read: cover property (state_q == cdt_pkg::CDT_BUS_RD);

endmodule

`default_nettype wire

// File: tb/cdt_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// External clock and gate pins of the timer pair
// ********************************************************
module cdt_pin_model (
  input  wire logic       hclk,
  input  wire logic [1:0] go,
  input  wire logic [1:0] hold,
  output logic [1:0]      pins
);
  logic [2:0] ph_q = 3'h0;
  // Six-cycle pulse phase, well above the synchroniser minimum
  always @(posedge hclk)
    ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
  // Pins rest low outside bursts; hold keeps a gate level up
  assign pins = hold | (go & {2{ph_q < 3'h3}});
endmodule

`default_nettype wire

// File: tb/cdt_timer_pair_tb.sv
`timescale 1ns/1ps
`default_nettype none

module cdt_timer_pair_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        idle_mode = 1'b0;
  logic [1:0]  go = 2'h0;
  logic [1:0]  hold = 2'h0;
  logic [1:0]  pins;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        adc_trigger;
  logic [31:0] r;
  int          num_errors = 0;
  int          n_compared = 0;
  int          adc_cnt = 0;

  cdt_timer_pair i_cdt_timer_pair (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp),
    .idle_mode(idle_mode), .even_ext_clock_pin(pins[0]),
    .odd_ext_clock_pin(pins[1]), .irq(irq), .adc_trigger(adc_trigger));
  cdt_pin_model i_cdt_pin_model (.hclk(hclk), .go(go), .hold(hold),
    .pins(pins));

  // Clock at 125 MHz
  initial forever #4 hclk = ~hclk;
  // Converter trigger pulses are counted for the trigger checks
  always @(posedge hclk)
    if (adc_trigger === 1'b1)
      adc_cnt <= adc_cnt + 1;

  // ********************************************************
  // Bus and compare tasks
  // ********************************************************
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Single word; wait states are waited out, read data taken at the last edge
  task automatic bx(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bx(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bx(1'b0, a, 32'h0);
  endtask
  // Reads status until a bit of m is set, bounded so a hang ends
  task automatic poll(input logic [1:0] m);
    int n;
    n = 0;
    do rd(8'h18); while ((r[1:0] & m) == 2'h0 && ++n < 300);
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  // Reset values, read-back of implemented bits, unmapped space
  task automatic t_regs();
    rd(8'h00);
    chk("even_ctrl_rst", 32'h0, r);
    rd(8'h10);
    chk("period_rst", 32'h0000FFFF, r);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00);
    chk("even_ctrl", 32'h0000A07A, r);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04);
    chk("odd_ctrl", 32'h0000A072, r);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    rd(8'h20);
    chk("unmapped", 32'h0, r);
    chk("hresp_okay", 32'h0, 32'(hresp));
  endtask
  // Sixteen-bit wrap at period; sticky flag, mask and interrupt
  task automatic t_wrap();
    wr(8'h18, 32'h3);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h2);
    wr(8'h00, 32'h8000);
    poll(2'h1);
    chk("even_event", 32'h1, r);
    chk("irq_masked", 32'h0, 32'(irq));
    wr(8'h1C, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq_on", 32'h1, 32'(irq));
    wr(8'h00, 32'h0);
    rd(8'h08);
    chk("count_in_period", 32'h1, 32'(r <= 32'h2));
    wr(8'h18, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq_clear", 32'h0, 32'(irq));
    chk("even_no_adc", 32'h0, 32'(adc_cnt));
  endtask
  // Every prescale code slows the count by its ratio
  task automatic t_pre();
    int sh[4] = '{0, 3, 6, 8};
    int e;
    wr(8'h10, 32'hFFFF);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h8000 | (k << 4));
      repeat (1536) @(posedge hclk);
      wr(8'h00, 32'h0);
      rd(8'h08);
      e = 768 >> sh[k];
      chk("prescaled", 32'h1, 32'(r >= e - 2 && r <= e + 3));
    end
  endtask
  // Idle halt freezes the count while idle; without the halt bit it counts in idle
  task automatic t_idle();
    idle_mode <= 1'b1;
    wr(8'h08, 32'h0);
    wr(8'h00, 32'hA000);
    repeat (64) @(posedge hclk);
    rd(8'h08);
    chk("halted", 32'h0, r);
    wr(8'h00, 32'h8000);
    repeat (64) @(posedge hclk);
    wr(8'h00, 32'h0);
    rd(8'h08);
    chk("idle_run", 32'h1, 32'(r >= 32'd30));
    idle_mode <= 1'b0;
  endtask
  // Odd timer alone counts its own pin and fires the trigger
  task automatic t_odd();
    int a;
    a = adc_cnt;
    wr(8'h0C, 32'h0);
    wr(8'h14, 32'h3);
    wr(8'h18, 32'h3);
    wr(8'h04, 32'h8002);
    repeat (64) @(posedge hclk);
    rd(8'h18);
    chk("odd_pin_still", 32'h0, r);
    go <= 2'h2;
    poll(2'h2);
    go <= 2'h0;
    wr(8'h04, 32'h0);
    chk("odd_event", 32'h2, r);
    chk("odd_adc", 32'h1, 32'(adc_cnt > a));
  endtask
  // Joined timer: even control and pin, odd control ignored
  task automatic t_pair();
    wr(8'h08, 32'hFFFE);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h1);
    wr(8'h18, 32'h3);
    wr(8'h04, 32'h2030);
    idle_mode <= 1'b1;
    wr(8'h00, 32'h800A);
    go <= 2'h1;
    poll(2'h3);
    go <= 2'h0;
    wr(8'h00, 32'h0);
    idle_mode <= 1'b0;
    chk("pair_event", 32'h2, r);
    rd(8'h0C);
    chk("pair_high", 32'h0, r);
  endtask
  // Gated accumulation counts while the pin is high, flags its fall
  task automatic t_gate();
    wr(8'h08, 32'h0);
    wr(8'h10, 32'hFFFF);
    wr(8'h18, 32'h3);
    wr(8'h00, 32'h8040);
    repeat (20) @(posedge hclk);
    rd(8'h08);
    chk("gate_low", 32'h0, r);
    hold <= 2'h1;
    repeat (40) @(posedge hclk);
    hold <= 2'h0;
    poll(2'h1);
    wr(8'h00, 32'h0);
    chk("gate_fall", 32'h1, r);
    rd(8'h08);
    chk("gate_count", 32'h1, 32'(r >= 32'd18 && r <= 32'd22));
  endtask

  // Main sequence after a 12-cycle reset
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_wrap();
    t_pre();
    t_idle();
    t_odd();
    t_pair();
    t_gate();
    finish_test();
  end
  // Watchdog: the run needs about 6700 cycles
  initial
  begin
    repeat (40000) @(posedge hclk);
    num_errors++;
    finish_test();
  end
endmodule

`default_nettype wire
